// *** inc/io_change_defines.svh ***
// Register offsets, field positions and reset values of the pin status and bid registers
`ifndef IO_CHANGE_DEFINES_SVH
`define IO_CHANGE_DEFINES_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_PORT_A_UPPER_PIN_STATUS 8'h13
`define ADDR_PORT_A_LOWER_PIN_STATUS 8'h14
`define ADDR_PORT_B_LOWER_PIN_STATUS 8'h1C
`define ADDR_PIN_CHANGE_IRQ_BID 8'h51
`define ADDR_TIMER_IRQ_BID 8'h52
`define ADDR_FLOW_CTRL_IRQ_BID 8'h53
`define ADDR_ADDR_MATCH_IRQ_BID 8'h54
`define ADDR_LOOPBACK_ERR_IRQ_BID 8'h55
// ----------------------------------------
// Field layout and values
// ----------------------------------------
`define FLAG_MSB 7
`define FLAG_LSB 4
`define LEVEL_MSB 3
`define LEVEL_LSB 0
`define UPPER_MSB 7
`define UPPER_LSB 4
`define LOWER_MSB 3
`define LOWER_LSB 0
`define PORT_B_LOWER_USED 4'hD
`define BID_RESET 8'h00
`define READ_IDLE 8'h00
`endif

// *** inc/io_change_pkg.sv ***
// Types shared by the pin status and bid register block
package io_change_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef logic [3:0] nibble_t;
endpackage : io_change_pkg

// *** testbench/io_change_detect_and_bid_regs_tb.sv ***
// Self-checking bench for the pin status and bid registers
`timescale 1ns/1ns
`default_nettype none
module io_change_detect_and_bid_regs_tb;
  logic mclk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, taken = 1'b0, ce = 1'b1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, want_a = 8'h00, want_b = 8'h00, dira = 8'h00, dirb = 8'h00;
  logic [7:0] rdata, pa, pb, ena, enb, old_a, old_b, ca, cb;
  logic [7:0] bid [5];
  logic [31:0] seed = 32'h9988_0a4e;
  logic [7:0] notes [$];
  int n_mismatch = 0, checks_done = 0;
  io_pin_model u_io_pin_model (.clk(mclk), .want_a(want_a), .want_b(want_b), .pins_a(pa), .pins_b(pb));
  io_change_detect_and_bid_regs u_io_change_detect_and_bid_regs (.MCLK(mclk), .RST_B(rst_b), .CE(ce),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .PORT_A_PINS(pa), .PORT_B_PINS(pb),
    .PORT_A_CHANGE_DETECT_ENABLE(ena), .PORT_B_CHANGE_DETECT_ENABLE(enb), .PORT_A_OUTPUT_DIR(dira),
    .PORT_B_OUTPUT_DIR(dirb), .PIN_CHANGE_IRQ_BID(bid[0]), .TIMER_IRQ_BID(bid[1]),
    .FLOW_CTRL_IRQ_BID(bid[2]), .ADDR_MATCH_IRQ_BID(bid[3]), .LOOPBACK_ERR_IRQ_BID(bid[4]));
  // ----------------------------------------
  // Bus tasks and result checking
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Read data is registered, so the note is compared one falling edge after the read is taken
  always @(posedge mclk) taken <= rd;
  always @(negedge mclk) if (taken) chk(rdata, notes.pop_front());
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(negedge mclk);
    addr = a;
    rd = 1'b1;
    notes.push_back(e);
    @(negedge mclk);
    rd = 1'b0;
  endtask : rd_reg
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge mclk);
    wr = 1'b0;
  endtask : wr_reg
  task automatic step();
    seed = lfsr(seed);
    old_a = want_a;
    old_b = want_b;
    {dirb, want_a, want_b, dira} = seed;
    repeat (3) @(negedge mclk);
    ca = (want_a ^ old_a) & ena & ~dira;
    cb = (want_b ^ old_b) & enb & ~dirb & 8'h0D;
    rd_reg(8'h14, {ca[3:0], want_a[3:0]});
    rd_reg(8'h13, {ca[7:4], want_a[7:4]});
    rd_reg(8'h1C, {cb[3:0], want_b[3:0] & 4'hD});
    rd_reg(8'h14, {4'h0, want_a[3:0]});
    rd_reg(8'h13, {4'h0, want_a[7:4]});
    rd_reg(8'h1C, {4'h0, want_b[3:0] & 4'hD});
  endtask : step
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run
  // ----------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------
  initial forever #50 mclk = ~mclk;
  initial begin
    #500000;
    n_mismatch++;
    complete_run();
  end
  initial begin
    // Enables stay fixed: re-enabling a pin whose level moved meanwhile raises no flag, as the detector keeps sampling
    seed = lfsr(seed);
    {ena, enb} = seed[15:0];
    repeat (20) @(negedge mclk);
    rst_b = 1'b1;
    chk(rdata, 8'h00);
    for (int i = 0; i < 5; i++) begin
      chk(bid[i], 8'h00);
      seed = lfsr(seed);
      wr_reg(8'h51 + 8'(i), seed[7:0]);
      chk(bid[i], seed[7:0]);
      rd_reg(8'h51 + 8'(i), seed[7:0]);
    end
    rd_reg(8'h20, 8'h00);
    wr_reg(8'h13, 8'hFF);
    repeat (12) step();
    // A low clock enable must freeze writes, read data, flag clearing and detection
    wr_reg(8'h51, 8'hA5);
    rd_reg(8'h51, 8'hA5);
    ce = 1'b0;
    old_a = want_a;
    want_a = ~want_a;
    repeat (3) @(negedge mclk);
    wr_reg(8'h51, 8'h5A);
    chk(bid[0], 8'hA5);
    rd_reg(8'h14, 8'hA5);
    ce = 1'b1;
    rd_reg(8'h14, {ena[3:0] & ~dira[3:0], want_a[3:0]});
    @(negedge mclk);
    complete_run();
  end
endmodule : io_change_detect_and_bid_regs_tb
`default_nettype wire

// *** testbench/io_pin_model.sv ***
// Model of the external pins that feed the port inputs
`timescale 1ns/1ns
`default_nettype none
module io_pin_model (
  input wire logic clk,
  input wire logic [7:0] want_a,
  input wire logic [7:0] want_b,
  output logic [7:0] pins_a = 8'h00,
  output logic [7:0] pins_b = 8'h00
);
  logic [15:0] hold = 16'h0000;
  // Two-step hand-off so a new level never lands in the same time step as the request
  always @(posedge clk) hold <= {want_a, want_b};
  always @(negedge clk) {pins_a, pins_b} <= hold;
endmodule : io_pin_model
`default_nettype wire

// *** verilog/io_change_detect_and_bid_regs.sv ***
// Pin change status registers and interrupt bid registers
// Notes on behaviour
// - Change-of-state bid high byte register
// - Xon/Xoff bid high byte register
// - Address recognition bid high byte register
// - Counter/timer bid high byte register
// - Loopback error bid high byte register
// - Flag reads zero if disabled or output
// - Level bits show live pin level
// - Port A lower: flags 3..0, levels 3..0
// - Port A upper: flags 7..4, levels 7..4
// - Port B lower: pins 3,2,0; 5,1 reserved
// - Detector keeps sampling while disabled; enable gates only the flags
`timescale 1ns/1ns
`default_nettype none
`include "io_change_defines.svh"
module io_change_detect_and_bid_regs
  import io_change_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic CE,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic [7:0] PORT_A_PINS,
  input wire logic [7:0] PORT_B_PINS,
  input wire logic [7:0] PORT_A_CHANGE_DETECT_ENABLE,
  input wire logic [7:0] PORT_B_CHANGE_DETECT_ENABLE,
  input wire logic [7:0] PORT_A_OUTPUT_DIR,
  input wire logic [7:0] PORT_B_OUTPUT_DIR,
  output logic [7:0] PIN_CHANGE_IRQ_BID,
  output logic [7:0] TIMER_IRQ_BID,
  output logic [7:0] FLOW_CTRL_IRQ_BID,
  output logic [7:0] ADDR_MATCH_IRQ_BID,
  output logic [7:0] LOOPBACK_ERR_IRQ_BID
);
  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  wire sel_a_upper = (ADDR == `ADDR_PORT_A_UPPER_PIN_STATUS);
  wire sel_a_lower = (ADDR == `ADDR_PORT_A_LOWER_PIN_STATUS);
  wire sel_b_lower = (ADDR == `ADDR_PORT_B_LOWER_PIN_STATUS);
  wire sel_pin_change = (ADDR == `ADDR_PIN_CHANGE_IRQ_BID);
  wire sel_ct = (ADDR == `ADDR_TIMER_IRQ_BID);
  wire sel_xon = (ADDR == `ADDR_FLOW_CTRL_IRQ_BID);
  wire sel_addr = (ADDR == `ADDR_ADDR_MATCH_IRQ_BID);
  wire sel_lbe = (ADDR == `ADDR_LOOPBACK_ERR_IRQ_BID);
  wire rd_go = RD && CE;
  wire wr_go = WR && CE;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // One packing for all three status registers keeps their layouts in step
  function automatic reg_byte_t status_byte(input nibble_t flag_nib, input nibble_t level_nib);
    return {flag_nib, level_nib};
  endfunction : status_byte
  // ----------------------------------------
  // Change detectors
  // ----------------------------------------
  logic [7:0] flags_a;
  logic [7:0] flags_b;
  logic [7:0] clear_a;
  logic [7:0] clear_b;
  // A status read clears all four flags of its nibble, including those masked from the read data
  assign clear_a = {{4{rd_go && sel_a_upper}}, {4{rd_go && sel_a_lower}}};
  assign clear_b = {4'h0, {4{rd_go && sel_b_lower}}};
  pin_change_detector #(.WIDTH(8)) detect_a (
    .clk(MCLK),
    .rst_b(RST_B),
    .ce(CE),
    .pins(PORT_A_PINS),
    .enable(PORT_A_CHANGE_DETECT_ENABLE),
    .clear(clear_a),
    .flags(flags_a)
  );
  pin_change_detector #(.WIDTH(8)) detect_b (
    .clk(MCLK),
    .rst_b(RST_B),
    .ce(CE),
    .pins(PORT_B_PINS),
    .enable(PORT_B_CHANGE_DETECT_ENABLE),
    .clear(clear_b),
    .flags(flags_b)
  );
  // ----------------------------------------
  // Status read data
  // ----------------------------------------
  // Output pins keep their detector running but never show a flag
  wire [7:0] shown_a = flags_a & PORT_A_CHANGE_DETECT_ENABLE & ~PORT_A_OUTPUT_DIR;
  wire [7:0] shown_b = flags_b & PORT_B_CHANGE_DETECT_ENABLE & ~PORT_B_OUTPUT_DIR;
  wire [7:0] status_a_lower = status_byte(shown_a[`LOWER_MSB:`LOWER_LSB],
                                          PORT_A_PINS[`LOWER_MSB:`LOWER_LSB]);
  wire [7:0] status_a_upper = status_byte(shown_a[`UPPER_MSB:`UPPER_LSB],
                                          PORT_A_PINS[`UPPER_MSB:`UPPER_LSB]);
  wire [3:0] b_flag_nib = shown_b[`LOWER_MSB:`LOWER_LSB] & `PORT_B_LOWER_USED;
  wire [3:0] b_level_nib = PORT_B_PINS[`LOWER_MSB:`LOWER_LSB] & `PORT_B_LOWER_USED;
  wire [7:0] status_b_lower = status_byte(b_flag_nib, b_level_nib);
  reg_byte_t read_mux;
  assign read_mux = sel_a_upper ? status_a_upper :
                    sel_a_lower ? status_a_lower :
                    sel_b_lower ? status_b_lower :
                    sel_pin_change ? PIN_CHANGE_IRQ_BID :
                    sel_ct ? TIMER_IRQ_BID :
                    sel_xon ? FLOW_CTRL_IRQ_BID :
                    sel_addr ? ADDR_MATCH_IRQ_BID :
                    sel_lbe ? LOOPBACK_ERR_IRQ_BID : `READ_IDLE;
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Read data is sampled in the read cycle so the level and the cleared flags agree
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      RDATA <= `READ_IDLE;
    end else if (rd_go) begin
      RDATA <= read_mux;
    end
  end
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      PIN_CHANGE_IRQ_BID <= `BID_RESET;
      TIMER_IRQ_BID <= `BID_RESET;
      FLOW_CTRL_IRQ_BID <= `BID_RESET;
      ADDR_MATCH_IRQ_BID <= `BID_RESET;
      LOOPBACK_ERR_IRQ_BID <= `BID_RESET;
    end else if (wr_go) begin
      if (sel_pin_change) PIN_CHANGE_IRQ_BID <= WDATA;
      if (sel_ct) TIMER_IRQ_BID <= WDATA;
      if (sel_xon) FLOW_CTRL_IRQ_BID <= WDATA;
      if (sel_addr) ADDR_MATCH_IRQ_BID <= WDATA;
      if (sel_lbe) LOOPBACK_ERR_IRQ_BID <= WDATA;
    end
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  change_bid_write_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    (wr_go && sel_pin_change) |=> (PIN_CHANGE_IRQ_BID == $past(WDATA)))
    else $error("change bid not written");
  xon_bid_write_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    (wr_go && sel_xon) |=> (FLOW_CTRL_IRQ_BID == $past(WDATA)))
    else $error("flow control bid not written");
  addr_bid_write_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    (wr_go && sel_addr) |=> (ADDR_MATCH_IRQ_BID == $past(WDATA)))
    else $error("address bid not written");
  timer_bid_hold_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    !(wr_go && sel_ct) |=> $stable(TIMER_IRQ_BID))
    else $error("timer bid changed without write");
  lbe_bid_write_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    (wr_go && sel_lbe) ##1 !(wr_go && sel_lbe) |=> (LOOPBACK_ERR_IRQ_BID == $past(WDATA, 2)))
    else $error("loopback bid lost");
  output_flag_mask_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    (rd_go && sel_a_lower) |=> ((RDATA[7:4] & $past(PORT_A_OUTPUT_DIR[3:0])) == 4'h0))
    else $error("flag shown on output pin");
  lower_level_read_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    (rd_go && sel_a_lower) |=> (RDATA[3:0] == $past(PORT_A_PINS[3:0])))
    else $error("port A lower level wrong");
  upper_level_read_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    (rd_go && sel_a_upper) |=> (RDATA[3:0] == $past(PORT_A_PINS[7:4])))
    else $error("port A upper level wrong");
  b_reserved_zero_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    (rd_go && sel_b_lower) |=> (RDATA[5] == 1'b0 && RDATA[1] == 1'b0))
    else $error("port B reserved bit set");
  disabled_no_flag_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    (CE && !PORT_A_CHANGE_DETECT_ENABLE[0]) |=> !flags_a[0])
    else $error("disabled detector holds flag");
  read_clears_flag_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    (rd_go && sel_a_lower && PORT_A_PINS[0] == $past(PORT_A_PINS[0])) ##1 (PORT_A_PINS[0] == $past(PORT_A_PINS[0]))
      |-> !flags_a[0])
    else $error("flag not cleared by read");
  timer_bid_write_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    (wr_go && sel_ct) |=> (TIMER_IRQ_BID == $past(WDATA)))
    else $error("timer bid not written");
  change_bid_hold_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    !(wr_go && sel_pin_change) |=> $stable(PIN_CHANGE_IRQ_BID))
    else $error("change bid changed without write");
  xon_bid_hold_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    !(wr_go && sel_xon) |=> $stable(FLOW_CTRL_IRQ_BID))
    else $error("flow control bid changed without write");
  addr_bid_hold_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    !(wr_go && sel_addr) |=> $stable(ADDR_MATCH_IRQ_BID))
    else $error("address bid changed without write");
  lbe_bid_hold_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    !(wr_go && sel_lbe) |=> $stable(LOOPBACK_ERR_IRQ_BID))
    else $error("loopback bid changed without write");
  upper_flag_mask_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    (rd_go && sel_a_upper)
      |=> ((RDATA[`FLAG_MSB:`FLAG_LSB] & $past(PORT_A_OUTPUT_DIR[`UPPER_MSB:`UPPER_LSB])) == 4'h0))
    else $error("flag shown on upper output pin");
  b_flag_mask_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    (rd_go && sel_b_lower)
      |=> ((RDATA[`FLAG_MSB:`FLAG_LSB] & $past(PORT_B_OUTPUT_DIR[`LOWER_MSB:`LOWER_LSB])) == 4'h0))
    else $error("flag shown on port B output pin");
  lower_disabled_zero_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    (rd_go && sel_a_lower)
      |=> ((RDATA[`FLAG_MSB:`FLAG_LSB] & ~$past(PORT_A_CHANGE_DETECT_ENABLE[`LOWER_MSB:`LOWER_LSB])) == 4'h0))
    else $error("flag shown on disabled lower pin");
  upper_disabled_zero_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    (rd_go && sel_a_upper)
      |=> ((RDATA[`FLAG_MSB:`FLAG_LSB] & ~$past(PORT_A_CHANGE_DETECT_ENABLE[`UPPER_MSB:`UPPER_LSB])) == 4'h0))
    else $error("flag shown on disabled upper pin");
  b_level_read_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    (rd_go && sel_b_lower)
      |=> (RDATA[`LEVEL_MSB:`LEVEL_LSB] == ($past(PORT_B_PINS[`LOWER_MSB:`LOWER_LSB]) & `PORT_B_LOWER_USED)))
    else $error("port B level wrong");
  a_enable_gate_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    CE |=> ((flags_a & ~$past(PORT_A_CHANGE_DETECT_ENABLE)) == 8'h00))
    else $error("port A flag set while disabled");
  b_enable_gate_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    CE |=> ((flags_b & ~$past(PORT_B_CHANGE_DETECT_ENABLE)) == 8'h00))
    else $error("port B flag set while disabled");
  transition_sets_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    (CE && $past(CE) && $past(RST_B) && PORT_A_CHANGE_DETECT_ENABLE[0]
      && (PORT_A_PINS[0] != $past(PORT_A_PINS[0]))) |=> flags_a[0])
    else $error("transition did not set flag");
  upper_read_clears_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    (rd_go && sel_a_upper && $past(CE) && $past(RST_B)
      && (PORT_A_PINS[4] == $past(PORT_A_PINS[4]))) |=> !flags_a[4])
    else $error("upper flag not cleared by read");
  b_read_clears_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    (rd_go && sel_b_lower && $past(CE) && $past(RST_B)
      && (PORT_B_PINS[0] == $past(PORT_B_PINS[0]))) |=> !flags_b[0])
    else $error("port B flag not cleared by read");
  flag_hold_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    (flags_a[0] && PORT_A_CHANGE_DETECT_ENABLE[0] && !(rd_go && sel_a_lower)) |=> flags_a[0])
    else $error("flag lost before read");
endmodule : io_change_detect_and_bid_regs
`default_nettype wire

// *** verilog/pin_change_detector.sv ***
// Per-pin level-transition detector with sticky change flags
`timescale 1ns/1ns
`default_nettype none
module pin_change_detector #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [WIDTH-1:0] pins,
  input wire logic [WIDTH-1:0] enable,
  input wire logic [WIDTH-1:0] clear,
  output logic [WIDTH-1:0] flags
);
  logic [WIDTH-1:0] prev;
  logic [WIDTH-1:0] next_flags;
  // ----------------------------------------
  // Detection
  // ----------------------------------------
  // A transition in the clearing cycle keeps the flag set; disabled pins hold no flag
  assign next_flags = enable & ((pins ^ prev) | (flags & ~clear));
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prev <= '0;
      flags <= '0;
    end else if (ce) begin
      prev <= pins;
      flags <= next_flags;
    end
  end
endmodule : pin_change_detector
`default_nettype wire
